// ===== pciad_pkg.sv
package pciad_pkg;

  // Bus widths and lane geometry.
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int LANE_W = 8;

  // Byte-swap select bit position inside the byte-order control register.
  localparam int BSWAP_BIT = 2;
  localparam logic [AD_W-1:0] BOC_RESET = 32'h0000_0000;

  // Linear burst order code driven on the two lowest lines in the address phase.
  localparam logic [1:0] BURST_LINEAR = 2'h0;

  // Bus commands used by the block.
  localparam logic [CBE_W-1:0] CMD_IO_READ = 4'h2;
  localparam logic [CBE_W-1:0] CMD_IO_WRITE = 4'h3;
  localparam logic [CBE_W-1:0] CMD_MEM_READ = 4'h6;
  localparam logic [CBE_W-1:0] CMD_MEM_WRITE = 4'h7;

  // Clock figures: bus rate limit and core clock period.
  localparam int BUS_MAX_MHZ = 33;
  localparam int CORE_PERIOD_NS = 4;

  // Bus cycle states.
  typedef enum logic [2:0] {
    PCIAD_IDLE,
    PCIAD_M_ADDR,
    PCIAD_M_DATA,
    PCIAD_M_TURN,
    PCIAD_S_DATA,
    PCIAD_S_TURN
  } pciad_state_t;

endpackage

// ===== pciad_pin_logic.sv
`timescale 1ns/1ps
// Summary of operation
// [RQ1] The first clock of a transaction carries the byte address on the shared lines and later clocks carry data.
// [RQ2] Data is little endian by default, lines 7 to 0 being the lowest byte and lines 31 to 24 the highest.
// [RQ3] With the byte-swap select bit set, FIFO data alone is byte-reversed to big endian.
// [RQ4] As master the address phase drives the double-word address on lines 31 to 2 and zeros on lines 1 and 0.
// [RQ5] When not master the block watches the shared lines for an address hitting its I/O slave space.
// [RQ6] The block drives the shared lines in data phases of master writes and slave reads.
// [RQ7] The block captures the shared lines in data phases of master reads and slave writes.
// [RQ8] While bus reset is high every shared pin is an input only, for the connectivity test chain.
// [RQ9] The command lines carry the command in the address phase and active-low byte enables in data phases.
// [RQ10] Byte enable 0 qualifies lines 7 to 0 and byte enable 3 qualifies lines 31 to 24.
// [RQ11] Byte enables follow physical lanes whatever the byte-swap setting.
// [RQ12] Every bus signal is sampled on the rising clock edge.
// [RQ13] The logic is static and works at any bus rate down to a stopped clock.
// [RQ14] As slave the block drives device-select low once it has decoded an access to itself.
// [RQ15] The block samples device-select to learn whether any agent claimed its own master access.
// [RQ16] As master the block asserts frame to begin, holds it, and releases it in the final data phase.
// [RQ17] Drivers for the shared lines are off whenever the block is not sending on them.
module pciad_pin_logic
  import pciad_pkg::*;
#(
  parameter logic [AD_W-1:0] IO_BASE = 32'h0000_1000,
  parameter logic [AD_W-1:0] IO_MASK = 32'hffff_ff80
) (
  // Clock, reset and enable.
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Byte-order control, the swap bit selects big endian for FIFO data.
  input wire logic [AD_W-1:0] byte_order_control_reg_i,
  // Address and data lines.
  input wire logic [AD_W-1:0] ad_i,
  output logic [AD_W-1:0] ad_o,
  output logic ad_oe_o,
  // Command and byte-enable lines, active low enables.
  input wire logic [CBE_W-1:0] cbe_n_i,
  output logic [CBE_W-1:0] cbe_n_o,
  output logic cbe_oe_o,
  // Frame, ready and select lines, all active low.
  input wire logic frame_n_i,
  output logic frame_n_o,
  output logic frame_oe_o,
  input wire logic irdy_n_i,
  output logic irdy_n_o,
  output logic irdy_oe_o,
  input wire logic trdy_n_i,
  output logic trdy_n_o,
  output logic trdy_oe_o,
  input wire logic devsel_n_i,
  output logic devsel_n_o,
  output logic devsel_oe_o,
  // Grant from the arbiter, active low.
  input wire logic gnt_n_i,
  // Master request from the DMA side.
  input wire logic mreq_i,
  input wire logic mwrite_i,
  input wire logic mfifo_i,
  input wire logic [AD_W-1:0] maddr_i,
  input wire logic [AD_W-1:0] mwdata_i,
  input wire logic [CBE_W-1:0] mbe_n_i,
  input wire logic mlast_i,
  output logic mbusy_o,
  output logic mdata_ack_o,
  output logic [AD_W-1:0] mrdata_o,
  output logic mclaimed_o,
  // Slave side towards the register file.
  input wire logic [AD_W-1:0] srdata_i,
  output logic swr_o,
  output logic srd_o,
  output logic [AD_W-1:0] saddr_o,
  output logic [AD_W-1:0] swdata_o,
  output logic [CBE_W-1:0] sbe_n_o
);

  pciad_state_t state;
  pciad_state_t next_state;
  logic m_write;
  logic m_fifo;
  logic [AD_W-1:0] m_addr;
  logic s_write;
  logic [AD_W-1:0] s_addr;
  logic frame_n_q;

  // Byte reversal, used in both directions of FIFO data.
  function automatic logic [AD_W-1:0] swap_bytes(input logic [AD_W-1:0] d);
    swap_bytes = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  // [RQ2] [RQ3] Lane order select.
  wire logic swap_on = byte_order_control_reg_i[BSWAP_BIT];
  wire logic m_swap = swap_on & m_fifo;
  wire logic [AD_W-1:0] m_wdata_lane = m_swap ? swap_bytes(mwdata_i) : mwdata_i;
  wire logic [AD_W-1:0] m_rdata_lane = m_swap ? swap_bytes(ad_i) : ad_i;

  // [RQ5] Slave address decode while not master.
  wire logic bus_idle = frame_n_i & irdy_n_i;
  // [RQ1] Address only on the falling frame edge, never in another agent's data phase.
  wire logic frame_start = ~frame_n_i & frame_n_q & (state == PCIAD_IDLE);
  wire logic io_cmd = (cbe_n_i == CMD_IO_READ) | (cbe_n_i == CMD_IO_WRITE);
  wire logic addr_hit = ((ad_i & IO_MASK) == (IO_BASE & IO_MASK));
  wire logic slave_hit = frame_start & io_cmd & addr_hit;
  wire logic m_start = (state == PCIAD_IDLE) & mreq_i & ~gnt_n_i & bus_idle & ~slave_hit;

  // Data phase completion conditions.
  wire logic m_xfer = (state == PCIAD_M_DATA) & ~trdy_n_i & ~irdy_n_o;
  wire logic s_xfer = (state == PCIAD_S_DATA) & ~irdy_n_i;

  // Previous frame level; it resets to the idle level, so a frame already low when reset ends is taken as a falling edge.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_n_q <= 1'b1;
    end else if (ce_i) begin
      frame_n_q <= frame_n_i;
    end
  end

  // Next state selection.
  always_comb begin
    next_state = state;
    case (state)
      PCIAD_IDLE: begin
        if (slave_hit) begin
          next_state = PCIAD_S_DATA;
        end else if (m_start) begin
          next_state = PCIAD_M_ADDR;
        end
      end
      PCIAD_M_ADDR: next_state = PCIAD_M_DATA;
      PCIAD_M_DATA: begin
        if (m_xfer & frame_n_o) begin
          next_state = PCIAD_M_TURN;
        end
      end
      PCIAD_S_DATA: begin
        if (s_xfer & frame_n_i) begin
          next_state = PCIAD_S_TURN;
        end
      end
      default: next_state = PCIAD_IDLE;
    endcase
  end

  // [RQ12] [RQ13] Static state, updated only on enabled rising edges.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= PCIAD_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // Captured transaction attributes.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      m_write <= 1'b0;
      m_fifo <= 1'b0;
      m_addr <= '0;
      s_write <= 1'b0;
      s_addr <= '0;
    end else if (ce_i) begin
      if (m_start) begin
        m_write <= mwrite_i;
        m_fifo <= mfifo_i;
        m_addr <= maddr_i;
      end
      // [RQ1] Address taken in the first clock of a slave access.
      if (slave_hit) begin
        s_write <= (cbe_n_i == CMD_IO_WRITE);
        s_addr <= ad_i;
      end
    end
  end

  // [RQ6] [RQ7] Data captured or presented in data phases.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mrdata_o <= '0;
      mclaimed_o <= 1'b0;
      swdata_o <= '0;
      sbe_n_o <= '1;
    end else if (ce_i) begin
      if (m_xfer & ~m_write) begin
        mrdata_o <= m_rdata_lane;
      end
      // [RQ15] Claim seen by any agent.
      if (state == PCIAD_M_DATA) begin
        mclaimed_o <= ~devsel_n_i;
      end else if (m_start) begin
        mclaimed_o <= 1'b0;
      end
      // [RQ11] Enables kept by physical lane.
      if (s_xfer & s_write) begin
        swdata_o <= ad_i;
        sbe_n_o <= cbe_n_i;
      end
    end
  end

  // Phase decode for pin drive.
  wire logic in_maddr = (state == PCIAD_M_ADDR);
  wire logic in_mdata = (state == PCIAD_M_DATA);
  wire logic in_sdata = (state == PCIAD_S_DATA);

  // [RQ8] [RQ17] Drivers only in owned phases, never while reset is high.
  // [RQ6] Write data or slave read data on the lines.
  assign ad_oe_o = ~rst_i & (in_maddr | (in_mdata & m_write) | (in_sdata & ~s_write));
  assign cbe_oe_o = ~rst_i & (in_maddr | in_mdata);
  assign frame_oe_o = ~rst_i & (in_maddr | in_mdata);
  assign irdy_oe_o = ~rst_i & (in_mdata | (state == PCIAD_M_TURN));
  assign trdy_oe_o = ~rst_i & (in_sdata | (state == PCIAD_S_TURN));
  assign devsel_oe_o = trdy_oe_o;

  // [RQ4] Double-word address with linear burst order.
  // [RQ1] Address first, then data.
  assign ad_o = in_maddr ? {m_addr[AD_W-1:2], BURST_LINEAR} : (in_mdata ? m_wdata_lane : srdata_i);
  // [RQ9] [RQ10] Command first, then lane enables.
  assign cbe_n_o = in_maddr ? (m_write ? CMD_MEM_WRITE : CMD_MEM_READ) : mbe_n_i;
  // [RQ16] Frame held until the final data phase.
  assign frame_n_o = ~(in_maddr | (in_mdata & ~mlast_i));
  assign irdy_n_o = ~in_mdata;
  // [RQ14] Select and ready driven once decoded.
  assign devsel_n_o = ~in_sdata;
  assign trdy_n_o = ~in_sdata;

  // Handshakes towards the inner side.
  assign mbusy_o = (state != PCIAD_IDLE) & (state != PCIAD_S_DATA) & (state != PCIAD_S_TURN);
  assign mdata_ack_o = m_xfer;
  assign srd_o = s_xfer & ~s_write;
  assign swr_o = s_xfer & s_write;
  assign saddr_o = s_addr;

  // [RQ4] Low address lines zero in the address phase.
  AST_ADDR_LOW: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ad_oe_o && in_maddr |-> ad_o[1:0] == 2'h0) else $error("Address phase low lines not zero.");
  // [RQ8] No drive in reset.
  AST_RESET_QUIET: assert property (@(posedge core_clk_i)
    rst_i |-> !ad_oe_o && !cbe_oe_o && !devsel_oe_o) else $error("Pins driven during reset.");
  // [RQ16] Frame asserted in the address phase, data follows.
  sequence s_mstart;
    ce_i && m_start;
  endsequence
  AST_FRAME_START: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_mstart |=> !frame_n_o && frame_oe_o) else $error("Frame not driven after start.");
  // [RQ14] Select driven the cycle after a decoded hit.
  AST_DEVSEL: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && slave_hit |=> !devsel_n_o && devsel_oe_o) else $error("Select not asserted on hit.");
  // [RQ6] Slave read drives the lines.
  AST_SREAD_DRIVE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    in_sdata && !s_write |-> ad_oe_o) else $error("Slave read not driving lines.");
  // [RQ7] Slave write never drives the lines.
  AST_SWRITE_FLOAT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    in_sdata && s_write |-> !ad_oe_o) else $error("Slave write drives lines.");
  // [RQ11] Enables pass unswapped.
  AST_BE_LANE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    in_mdata |-> cbe_n_o == mbe_n_i) else $error("Byte enables altered.");
  // [RQ3] Non-FIFO data never swapped.
  AST_NOSWAP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    in_mdata && m_write && !m_fifo |-> ad_o == mwdata_i) else $error("Non-FIFO data swapped.");
  // [RQ17] No line drive while idle.
  AST_IDLE_FLOAT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == PCIAD_IDLE |-> !ad_oe_o && !cbe_oe_o && !frame_oe_o) else $error("Idle drive.");

endmodule // pciad_pin_logic

// ===== pciad_target_model.sv
`timescale 1ns/1ps
module pciad_target_model
  import pciad_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Bus lines as the target sees them.
  input wire logic frame_n_i,
  input wire logic irdy_n_i,
  input wire logic [CBE_W-1:0] cbe_n_i,
  // Wait states and read data chosen by the bench.
  input wire logic [3:0] wait_i,
  input wire logic [AD_W-1:0] rdata_i,
  // Target answer.
  output logic trdy_n_o,
  output logic devsel_n_o,
  output logic [AD_W-1:0] ad_o,
  output logic ad_oe_o
);
  logic act;
  logic rd;
  logic [3:0] cnt;
  // Only memory commands are claimed, so the bench's I/O cycles reach the block alone.
  // address phase sampled on the rising edge
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act <= 1'b0;
      rd <= 1'b0;
      cnt <= 4'h0;
      trdy_n_o <= 1'b1;
      devsel_n_o <= 1'b1;
    end else if (!act && !frame_n_i && irdy_n_i && cbe_n_i[3:1] == 3'h3) begin
      act <= 1'b1;
      rd <= (cbe_n_i == CMD_MEM_READ);
      cnt <= wait_i;
      devsel_n_o <= 1'b0;
    end else if (act && !irdy_n_i && !trdy_n_o) begin
      trdy_n_o <= 1'b1;
      cnt <= wait_i;
      act <= !frame_n_i;
      devsel_n_o <= frame_n_i;
    end else if (act && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (act) begin
      trdy_n_o <= 1'b0;
    end
  end
  // read data is driven only after the claim.
  assign ad_oe_o = act && rd && !devsel_n_o;
  assign ad_o = rdata_i;
endmodule // pciad_target_model

// ===== pciad_pin_logic_tb.sv
`timescale 1ns/1ps
module pciad_pin_logic_tb;
  import pciad_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, b_oe = 1'b0, b_fr = 1'b1, b_ir = 1'b1, gnt_n = 1'b1;
  logic mreq = 1'b0, mwr = 1'b0, mff = 1'b0, mlast = 1'b1;
  logic [AD_W-1:0] boc = '0, b_ad = '0, maddr = '0, mwd = '0, srd_d = '0, rdat = '0;
  logic [CBE_W-1:0] b_cbe = 4'hf, mbe = 4'hf;
  logic [3:0] wt = 4'h0;
  logic [7:0] cyc = 8'h0;
  int n_errors = 0;
  int tests_run = 0;
  logic [AD_W-1:0] ad_o, mrd, sad, swd, t_ad;
  logic [CBE_W-1:0] cbe_o, sbe;
  logic ad_oe, cbe_oe, fr_o, fr_oe, ir_o, ir_oe, tr_o, tr_oe, dv_o, dv_oe, mbusy, mack, mclm, swr, srd, t_tr, t_dv, t_oe;
  // A released data bus shows a pattern that moves each cycle; control lines float high.
  wire logic [AD_W-1:0] ad = ad_oe ? ad_o : t_oe ? t_ad : b_oe ? b_ad : {4{cyc}};
  wire logic [CBE_W-1:0] cbe = cbe_oe ? cbe_o : b_cbe;
  wire logic frame_n = fr_oe ? fr_o : b_fr;
  wire logic irdy_n = ir_oe ? ir_o : b_ir;
  wire logic trdy_n = tr_oe ? tr_o : t_tr;
  wire logic devsel_n = dv_oe ? dv_o : t_dv;
  always #2 core_clk = ~core_clk;
  always_ff @(posedge core_clk) cyc <= cyc + 8'h1;
  pciad_pin_logic uut (.core_clk_i(core_clk), .rst_i(rst), .ce_i(1'b1), .byte_order_control_reg_i(boc),
    .ad_i(ad), .ad_o(ad_o), .ad_oe_o(ad_oe), .cbe_n_i(cbe), .cbe_n_o(cbe_o), .cbe_oe_o(cbe_oe),
    .frame_n_i(frame_n), .frame_n_o(fr_o), .frame_oe_o(fr_oe), .irdy_n_i(irdy_n), .irdy_n_o(ir_o),
    .irdy_oe_o(ir_oe), .trdy_n_i(trdy_n), .trdy_n_o(tr_o), .trdy_oe_o(tr_oe), .devsel_n_i(devsel_n),
    .devsel_n_o(dv_o), .devsel_oe_o(dv_oe), .gnt_n_i(gnt_n), .mreq_i(mreq), .mwrite_i(mwr), .mfifo_i(mff),
    .maddr_i(maddr), .mwdata_i(mwd), .mbe_n_i(mbe), .mlast_i(mlast), .mbusy_o(mbusy), .mdata_ack_o(mack),
    .mrdata_o(mrd), .mclaimed_o(mclm), .srdata_i(srd_d), .swr_o(swr), .srd_o(srd), .saddr_o(sad),
    .swdata_o(swd), .sbe_n_o(sbe));
  pciad_target_model tgt (.core_clk_i(core_clk), .rst_i(rst), .frame_n_i(frame_n), .irdy_n_i(irdy_n),
    .cbe_n_i(cbe), .wait_i(wt), .rdata_i(rdat), .trdy_n_o(t_tr), .devsel_n_o(t_dv), .ad_o(t_ad), .ad_oe_o(t_oe));
  task automatic chk(input logic [AD_W-1:0] got, input logic [AD_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Errors %0d in %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Grant is offered during reset to show that no driver turns on then.
  task automatic t_reset();
    gnt_n = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({ad_oe, cbe_oe, fr_oe, ir_oe, tr_oe, dv_oe}, 6'h00);
    rst = 1'b0;
    gnt_n = 1'b1;
    @(negedge core_clk);
  endtask
  // One master data phase against the target model, with w plus one wait states.
  task automatic t_master(input logic wr, input logic ff, input logic sw, input logic [AD_W-1:0] a,
      input logic [AD_W-1:0] d, input logic [CBE_W-1:0] be, input logic [3:0] w);
    logic [AD_W-1:0] e;
    int i;
    e = (ff && sw) ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    boc = {{(AD_W-1){1'b0}}, sw} << BSWAP_BIT;
    {mwr, mff, maddr, mwd, mbe, wt, rdat, mreq, gnt_n} = {wr, ff, a, d, be, w, d, 2'b10};
    for (i = 0; i < 20 && frame_n !== 1'b0; i++) @(negedge core_clk);
    chk(ad, {a[31:2], BURST_LINEAR});
    chk(cbe, wr ? CMD_MEM_WRITE : CMD_MEM_READ);
    {mreq, gnt_n} = 2'b01;
    for (i = 0; i < 20 && !(irdy_n === 1'b0 && trdy_n === 1'b0); i++) @(negedge core_clk);
    chk(ad, wr ? e : d);
    chk(cbe, be);
    chk(frame_n, 1'b1);
    chk(mack, 1'b1);
    for (i = 0; i < 20 && mbusy !== 1'b0; i++) @(negedge core_clk);
    if (!wr) chk(mrd, e);
    chk(mclm, 1'b1);
    chk({ad_oe, cbe_oe}, 2'h0);
  endtask
  // One single-phase I/O access from the bench acting as initiator.
  task automatic t_slave(input logic wr, input logic [AD_W-1:0] a, input logic [AD_W-1:0] d, input logic hit);
    int n;
    srd_d = d;
    {b_fr, b_cbe, b_ad, b_oe} = {1'b0, wr ? CMD_IO_WRITE : CMD_IO_READ, a, 1'b1};
    @(negedge core_clk);
    chk(devsel_n, !hit);
    {b_fr, b_ir, b_cbe, b_ad, b_oe} = {2'b10, 4'h5, d, wr};
    #1;
    if (hit && !wr) chk(ad, d);
    n = (wr ? swr : srd) === 1'b1;
    @(negedge core_clk);
    {b_ir, b_oe, b_cbe} = {2'b10, 4'hf};
    n += (wr ? swr : srd) === 1'b1;
    repeat (2) begin
      @(negedge core_clk);
      n += (wr ? swr : srd) === 1'b1;
    end
    chk(n, hit);
    if (hit) chk(sad, a);
    if (hit && wr) chk(swd, d);
    if (hit && wr) chk(sbe, 4'h5);
  endtask
  // Two-phase master write burst: frame stays low until the final phase is reached.
  task automatic t_burst();
    int i;
    {mwr, mff, maddr, mwd, mbe, wt, mlast, mreq, gnt_n} = {2'b10, 32'h0000_4000, 32'h0102_0304, 8'h00, 3'b010};
    for (i = 0; i < 20 && frame_n !== 1'b0; i++) @(negedge core_clk);
    {mreq, gnt_n} = 2'b01;
    for (i = 0; i < 20 && !(irdy_n === 1'b0 && trdy_n === 1'b0); i++) @(negedge core_clk);
    chk(frame_n, 1'b0);
    chk(ad, 32'h0102_0304);
    @(negedge core_clk);
    {mwd, mlast} = {32'h0506_0708, 1'b1};
    for (i = 0; i < 20 && !(irdy_n === 1'b0 && trdy_n === 1'b0); i++) @(negedge core_clk);
    chk(frame_n, 1'b1);
    chk(ad, 32'h0506_0708);
    chk(mack, 1'b1);
    for (i = 0; i < 20 && mbusy !== 1'b0; i++) @(negedge core_clk);
    chk(mclm, 1'b1);
  endtask
  // Reset in the middle of a master data phase must drop every driver and return to idle.
  task automatic t_midreset();
    int i;
    {mwr, mff, wt, mreq, gnt_n} = {2'b10, 4'hf, 2'b10};
    for (i = 0; i < 20 && ir_oe !== 1'b1; i++) @(negedge core_clk);
    {mreq, gnt_n} = 2'b01;
    @(negedge core_clk);
    chk(ad_oe, 1'b1);
    rst = 1'b1;
    @(negedge core_clk);
    chk({ad_oe, cbe_oe, fr_oe, ir_oe, tr_oe, dv_oe}, 6'h00);
    rst = 1'b0;
    @(negedge core_clk);
    chk(mbusy, 1'b0);
  endtask
  initial begin
    #20000;
    n_errors++;
    conclude();
  end
  initial begin
    t_reset();
    t_master(1'b1, 1'b1, 1'b1, 32'h0000_2346, 32'h1122_3344, 4'h0, 4'h0);
    t_master(1'b0, 1'b1, 1'b1, 32'h8000_0011, 32'ha1b2_c3d4, 4'h0, 4'h2);
    t_master(1'b0, 1'b0, 1'b1, 32'h0000_0fff, 32'h5566_7788, 4'h0, 4'h1);
    t_master(1'b1, 1'b0, 1'b0, 32'hffff_fffe, 32'h0bad_f00d, 4'h6, 4'h0);
    t_burst();
    t_midreset();
    t_slave(1'b1, 32'h0000_1004, 32'hcafe_0001, 1'b1);
    t_slave(1'b0, 32'h0000_107c, 32'h0123_4567, 1'b1);
    t_slave(1'b1, 32'h0000_1080, 32'h0000_0000, 1'b0);
    conclude();
  end
endmodule // pciad_pin_logic_tb
